// >>> verilog/pcar_regs.sv
// prediction control and coprocessor permission registers
// assumes one move per cycle from the pipeline, answered next cycle
`timescale 1ns/10ps
module pcar_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // coprocessor move request
  input wire logic i_move_valid,
  input wire logic i_move_write,
  input wire logic i_priv,
  input wire logic [2:0] i_op1,
  input wire logic [3:0] i_crn,
  input wire logic [3:0] i_crm,
  input wire logic [2:0] i_op2,
  input wire logic [31:0] i_wdata,
  // coprocessor use check
  input wire logic i_cp_valid,
  input wire logic [3:0] i_cp_num,
  // system configuration
  input wire logic [13:0] i_cp_present,
  input wire logic i_flow_predict_enable,
  // move answer
  output logic o_move_done,
  output logic [31:0] o_rdata,
  output logic o_undef,
  // coprocessor use answer
  output logic o_cp_undef,
  // prediction controls and coprocessor permissions
  output logic o_static_predict_enable,
  output logic o_dynamic_predict_enable,
  output logic o_return_stack_enable,
  output logic [27:0] o_coproc_permission
);
  import pcar_pkg::*;
  typedef struct packed {
    logic [2:0] pred;
    logic [27:0] perm;
    logic done;
    logic [31:0] rdata;
    logic undef;
    logic cp_undef;
    logic [2:0] feat;
  } pcar_state_type;
  pcar_state_type s_q, s_d;
  pcar_move_if mv ();
  logic allow;
  assign mv.op1 = i_op1;
  assign mv.primary_coproc_reg_number = i_crn;
  assign mv.secondary_coproc_reg_number = i_crm;
  assign mv.op2 = i_op2;
  pcar_decode u_dec (
    .mv(mv)
  );
  pcar_perm_check u_chk (
    .i_perm(s_q.perm),
    .i_cp_num(i_cp_num),
    .i_priv(i_priv),
    .o_allow(allow)
  );
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.undef = 1'b0;
    s_d.rdata = 32'h00000000;
    s_d.cp_undef = i_cp_valid && !allow;
    if (i_move_valid && mv.sel != pcar_sel_none) begin
      s_d.done = 1'b1;
      if (!i_priv) begin
        s_d.undef = 1'b1;
      end else if (mv.sel == pcar_sel_pred) begin
        if (i_move_write) begin
          s_d.pred = i_wdata[2:0];
        end else begin
          s_d.rdata = {29'h0000000, s_q.pred};
        end
      end else begin
        if (i_move_write) begin
          for (int n = 0; n < pcar_ncp; n++) begin
            // absent coprocessors keep 00
            if (i_cp_present[n]) begin
              s_d.perm[2*n +: 2] = i_wdata[2*n +: 2];
            end
          end
        end else begin
          s_d.rdata = {4'h0, s_q.perm};
        end
      end
    end
    if (i_move_valid && mv.sel == pcar_sel_perm && !i_priv) begin
      s_d.undef = 1'b1;
    end
    // prediction enable outputs gated by global enable
    s_d.feat = i_flow_predict_enable ? s_d.pred : 3'h0;
    if (i_reset) begin
      s_d.pred = pcar_pred_reset;
      s_d.perm = pcar_perm_reset;
      s_d.done = 1'b0;
      s_d.rdata = 32'h00000000;
      s_d.undef = 1'b0;
      s_d.cp_undef = 1'b0;
      s_d.feat = 3'h0;
    end
  end
  always_ff @(posedge i_clk) begin
    s_q <= s_d;
  end
  assign o_move_done = s_q.done;
  assign o_rdata = s_q.rdata;
  assign o_undef = s_q.undef;
  assign o_cp_undef = s_q.cp_undef;
  assign o_static_predict_enable = s_q.feat[pcar_bit_static];
  assign o_dynamic_predict_enable = s_q.feat[pcar_bit_dynamic];
  assign o_return_stack_enable = s_q.feat[pcar_bit_retstack];
  assign o_coproc_permission = s_q.perm;

  chk_user_undef: assert property (@(posedge i_clk) disable iff (i_reset)
    i_move_valid && !i_priv && mv.sel != pcar_sel_none |=> o_undef && o_move_done)
    else $error("user move not refused");
  chk_pred_select: assert property (@(posedge i_clk) disable iff (i_reset)
    i_move_valid && i_priv && i_move_write && mv.sel == pcar_sel_pred
    |=> s_q.pred == $past(i_wdata[2:0]))
    else $error("prediction write lost");
  chk_perm_select: assert property (@(posedge i_clk) disable iff (i_reset)
    i_move_valid && i_priv && !i_move_write && mv.sel == pcar_sel_perm
    |=> o_rdata == {4'h0, $past(s_q.perm)})
    else $error("permission read wrong");
  chk_feat_gate: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_flow_predict_enable |=> !o_static_predict_enable && !o_dynamic_predict_enable
      && !o_return_stack_enable)
    else $error("prediction not gated");
  chk_dyn_follow: assert property (@(posedge i_clk) disable iff (i_reset)
    i_flow_predict_enable |=> o_dynamic_predict_enable == s_q.pred[pcar_bit_dynamic])
    else $error("dynamic enable wrong");
  chk_absent_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    i_move_valid && i_priv && i_move_write && mv.sel == pcar_sel_perm && !i_cp_present[5]
    && s_q.perm[11:10] == 2'h0 |=> s_q.perm[11:10] == 2'h0)
    else $error("absent field written");
  chk_reset_perm: assert property (@(posedge i_clk)
    i_reset |=> s_q.perm == pcar_perm_reset && s_q.pred == pcar_pred_reset)
    else $error("reset values wrong");
  chk_denied_cp: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cp_valid && i_cp_num < 4'hE && s_q.perm[{i_cp_num, 1'b0} +: 2] == 2'h0 |=> o_cp_undef)
    else $error("denied access allowed");
  chk_sys_cp: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cp_valid && i_cp_num >= 4'hE |=> !o_cp_undef)
    else $error("debug or system blocked");
  chk_pred_reserved: assert property (@(posedge i_clk) disable iff (i_reset)
    o_move_done && !o_undef && $past(mv.sel == pcar_sel_pred) |-> o_rdata[31:3] == 29'h0)
    else $error("reserved bits nonzero");
  cov_user_trap: cover property (@(posedge i_clk) o_undef);
  cov_perm_write: cover property (@(posedge i_clk)
    i_move_valid && i_priv && i_move_write && mv.sel == pcar_sel_perm);
  cov_cp_denied: cover property (@(posedge i_clk) o_cp_undef);
endmodule // pcar_regs

// >>> verilog/pcar_pkg.sv
// constants and types for the prediction control and coprocessor permission registers
// assumes one clock domain and the core's synchronous reset
// Function
// - static prediction enable bit gated by global enable, resets to one.
// - bit 1 enables dynamic prediction under global enable, resets to one.
// - bit 0 enables return stack under global enable, resets to one.
// - prediction register privileged read/write; user access raises undefined exception.
// - prediction register selected by opcode1 0, primary 1, secondary 0, opcode2 1.
// - permission register governs coprocessors 0 to 13, never debug or system.
// - permission register 32 bits, fourteen fields, bits 31:28 read zero.
// - field 00 denies, 01 privileged only, 10 reserved, 11 full access.
// - writes to absent coprocessor fields ignored; field reads 00.
// - reset sets all permission fields to 00, access denied.
// - permission register privileged read/write; user access raises undefined exception.
// - permission register selected by opcode1 0, primary 1, secondary 0, opcode2 2.
// - prediction register bits 31:3 reserved, read as zero.
package pcar_pkg;
  localparam int unsigned pcar_ncp = 14;
  localparam logic [2:0] pcar_op1_sel = 3'h0;
  localparam logic [3:0] pcar_crn_sel = 4'h1;
  localparam logic [3:0] pcar_crm_sel = 4'h0;
  localparam logic [2:0] pcar_op2_pred = 3'h1;
  localparam logic [2:0] pcar_op2_perm = 3'h2;
  localparam int unsigned pcar_bit_static = 2;
  localparam int unsigned pcar_bit_dynamic = 1;
  localparam int unsigned pcar_bit_retstack = 0;
  localparam logic [2:0] pcar_pred_reset = 3'h7;
  localparam logic [27:0] pcar_perm_reset = 28'h0000000;
  localparam logic [1:0] pcar_perm_denied = 2'h0;
  localparam logic [1:0] pcar_perm_priv = 2'h1;
  localparam logic [1:0] pcar_perm_full = 2'h3;
  typedef enum logic [1:0] {
    pcar_sel_none = 2'b00,
    pcar_sel_pred = 2'b01,
    pcar_sel_perm = 2'b10
  } pcar_sel_type;
endpackage

// >>> verilog/pcar_move_if.sv
// decoded coprocessor move carried between decoder and top
// assumes the top drives the decoder's inputs
`timescale 1ns/10ps
interface pcar_move_if;
  import pcar_pkg::*;
  logic [2:0] op1;
  logic [3:0] primary_coproc_reg_number;
  logic [3:0] secondary_coproc_reg_number;
  logic [2:0] op2;
  pcar_sel_type sel;
  modport dec (input op1, primary_coproc_reg_number, secondary_coproc_reg_number, op2, output sel);
  modport top (output op1, primary_coproc_reg_number, secondary_coproc_reg_number, op2, input sel);
endinterface

// >>> verilog/pcar_decode.sv
// register select decode for system control coprocessor moves
// assumes the move fields are valid whenever a move is presented
`timescale 1ns/10ps
module pcar_decode (
  pcar_move_if.dec mv
);
  import pcar_pkg::*;
  always_comb begin
    mv.sel = pcar_sel_none;
    if (mv.op1 == pcar_op1_sel && mv.primary_coproc_reg_number == pcar_crn_sel && mv.secondary_coproc_reg_number == pcar_crm_sel) begin
      if (mv.op2 == pcar_op2_pred) begin
        mv.sel = pcar_sel_pred;
      end else if (mv.op2 == pcar_op2_perm) begin
        mv.sel = pcar_sel_perm;
      end
    end
  end
endmodule // pcar_decode

// >>> verilog/pcar_perm_check.sv
// permission lookup for a coprocessor instruction
// assumes coprocessor numbers 14 and 15 are handled elsewhere
`timescale 1ns/10ps
module pcar_perm_check (
  input wire logic [27:0] i_perm,
  input wire logic [3:0] i_cp_num,
  input wire logic i_priv,
  output logic o_allow
);
  import pcar_pkg::*;
  function automatic logic [1:0] pcar_field(input logic [27:0] r, input logic [3:0] n);
    pcar_field = r[{n, 1'b0} +: 2];
  endfunction
  logic [1:0] f;
  always_comb begin
    f = pcar_field(i_perm, i_cp_num);
    o_allow = 1'b1;
    if (i_cp_num < 4'(pcar_ncp)) begin
      unique case (f)
        pcar_perm_full: o_allow = 1'b1;
        pcar_perm_priv: o_allow = i_priv;
        default: o_allow = 1'b0; // reserved treated as denied
      endcase
    end
  end
endmodule // pcar_perm_check

// >>> tb/pcar_core_model.sv
// pipeline model issuing system control coprocessor moves
// assumes the registers answer at the taking edge, read at the following falling edge
`timescale 1ns/10ps
module pcar_core_model (
  // clock
  input wire logic i_clk,
  // move request
  output logic o_move_valid,
  output logic o_move_write,
  output logic [2:0] o_op1,
  output logic [3:0] o_crn,
  output logic [3:0] o_crm,
  output logic [2:0] o_op2,
  output logic [31:0] o_wdata,
  // move answer
  input wire logic i_move_done,
  input wire logic [31:0] i_rdata,
  input wire logic i_undef
);
  initial begin
    {o_move_valid, o_move_write, o_op1, o_crn, o_crm, o_op2} = 16'h0000;
    o_wdata = 32'h00000000;
  end
  // one move, held across exactly one taking edge
  task automatic move(input logic wr, input logic [2:0] op1, input logic [3:0] primary_coproc_reg_number,
      input logic [2:0] op2, input logic [31:0] wd, output logic dn,
      output logic [31:0] rd, output logic ud);
    @(posedge i_clk);
    o_move_valid <= 1'b1;
    {o_move_write, o_op1, o_crn, o_op2, o_wdata} <= {wr, op1, primary_coproc_reg_number, op2, wd};
    @(posedge i_clk);
    o_move_valid <= 1'b0;
    // stale data must not look valid once released
    o_wdata <= ~wd;
    @(negedge i_clk);
    dn = i_move_done;
    rd = i_rdata;
    ud = i_undef;
  endtask
endmodule // pcar_core_model

// >>> tb/prediction_and_coproc_access_regs_bench.sv
// self-checking bench for the prediction and permission registers
// assumes the pipeline model owns the move fields, the bench the rest
`timescale 1ns/10ps
module prediction_and_coproc_access_regs_bench;
  logic i_clk, i_reset, mv, mw, pv, cp_valid, flow_en, done, undef, cp_undef, dn, ud;
  logic st_en, dy_en, rs_en;
  logic [2:0] op1, op2;
  logic [3:0] primary_coproc_reg_number, secondary_coproc_reg_number, cp_num;
  logic [31:0] wdata, rdata, rd, wd;
  logic [13:0] cp_present;
  logic [27:0] perm;
  int failures = 0;
  int cmp_count = 0;
  pcar_regs i_pcar_regs (.i_clk(i_clk), .i_reset(i_reset), .i_move_valid(mv),
    .i_move_write(mw), .i_priv(pv), .i_op1(op1), .i_crn(primary_coproc_reg_number), .i_crm(secondary_coproc_reg_number), .i_op2(op2),
    .i_wdata(wdata), .i_cp_valid(cp_valid), .i_cp_num(cp_num), .i_cp_present(cp_present),
    .i_flow_predict_enable(flow_en), .o_move_done(done), .o_rdata(rdata), .o_undef(undef),
    .o_cp_undef(cp_undef), .o_static_predict_enable(st_en),
    .o_dynamic_predict_enable(dy_en), .o_return_stack_enable(rs_en),
    .o_coproc_permission(perm));
  pcar_core_model i_pcar_core_model (.i_clk(i_clk), .o_move_valid(mv), .o_move_write(mw),
    .o_op1(op1), .o_crn(primary_coproc_reg_number), .o_crm(secondary_coproc_reg_number), .o_op2(op2), .o_wdata(wdata),
    .i_move_done(done), .i_rdata(rdata), .i_undef(undef));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic p, input logic [2:0] o2,
      input logic [31:0] d, input logic [31:0] erd, input logic eud);
    pv <= p;
    i_pcar_core_model.move(w, 3'h0, 4'h1, o2, d, dn, rd, ud);
    check("done", {31'h0, dn}, 32'h1);
    check("rdata", rd, erd);
    check("undef", {31'h0, ud}, {31'h0, eud});
  endtask
  task automatic cpq(input logic [3:0] n, input logic p, input logic exp);
    @(posedge i_clk);
    cp_valid <= 1'b1;
    cp_num <= n;
    pv <= p;
    @(posedge i_clk);
    cp_valid <= 1'b0;
    @(negedge i_clk);
    check("cp_undef", {31'h0, cp_undef}, {31'h0, exp});
  endtask
  function automatic logic [31:0] feat();
    return {29'h0, st_en, dy_en, rs_en};
  endfunction
  initial begin
    #(20 * 3000);
    failures++;
    end_of_test;
  end
  initial begin
    {i_reset, cp_valid, pv, flow_en} = 4'b1001;
    cp_num = 4'h0;
    // coprocessor 5 left absent
    cp_present = 14'h3fdf;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    xfer(1'b0, 1'b1, 3'h1, 32'h0, 32'h7, 1'b0);
    xfer(1'b0, 1'b1, 3'h2, 32'h0, 32'h0, 1'b0);
    check("features", feat(), 32'h7);
    wd = rd & ~32'h2;
    xfer(1'b1, 1'b1, 3'h1, 32'h5, 32'h0, 1'b0);
    xfer(1'b0, 1'b1, 3'h1, 32'h0, 32'h5, 1'b0);
    check("features", feat(), 32'h5);
    xfer(1'b1, 1'b1, 3'h1, 32'h4, 32'h0, 1'b0);
    check("features", feat(), 32'h4);
    flow_en <= 1'b0;
    repeat (2) @(negedge i_clk);
    check("features", feat(), 32'h0);
    flow_en <= 1'b1;
    xfer(1'b1, 1'b1, 3'h1, 32'h7, 32'h0, 1'b0);
    xfer(1'b1, 1'b0, 3'h1, 32'h0, 32'h0, 1'b1);
    xfer(1'b0, 1'b0, 3'h1, 32'h0, 32'h0, 1'b1);
    xfer(1'b0, 1'b1, 3'h1, 32'h0, 32'h7, 1'b0);
    xfer(1'b1, 1'b0, 3'h2, 32'h0fffffe4, 32'h0, 1'b1);
    xfer(1'b0, 1'b1, 3'h2, 32'h0, 32'h0, 1'b0);
    i_pcar_core_model.move(1'b0, 3'h0, 4'h1, 3'h3, 32'h0, dn, rd, ud);
    check("no_select", {31'h0, dn}, 32'h0);
    i_pcar_core_model.move(1'b1, 3'h1, 4'h1, 3'h2, 32'h3, dn, rd, ud);
    check("no_select", {31'h0, dn}, 32'h0);
    // cp0 denied, cp1 privileged, cp2 reserved, cp3 full, others full except absent cp5, which stays denied
    xfer(1'b1, 1'b1, 3'h2, 32'h0fffffe4, 32'h0, 1'b0);
    repeat (4) @(posedge i_clk);
    xfer(1'b0, 1'b1, 3'h2, 32'h0, 32'h0ffff3e4, 1'b0);
    check("perm_out", {4'h0, perm}, 32'h0ffff3e4);
    for (int n = 0; n < 4; n++) begin
      cpq(n[3:0], 1'b1, n == 0 || n == 2);
      cpq(n[3:0], 1'b0, n != 3);
    end
    cpq(4'he, 1'b0, 1'b0);
    cpq(4'hf, 1'b0, 1'b0);
    cpq(4'h5, 1'b1, 1'b1);
    end_of_test;
  end
endmodule // prediction_and_coproc_access_regs_bench
